// ===== src/sdp_debug_port.v
// Behaviour
// - Character is one low start, eight data bits LSB first, one high stop.
// - After reset stay idle until host data arrives.
// - Measure eight low bits of 80h and program bit-rate generator.
// - Autobaud runs on system clock, down to clock divided by 512.
// - Bit rates up to clock/8 recommended, clock/4 absolute ceiling.
// - Nine or more low bit times is break; reset autobaud.
// - Low stop bit flags a framing error.
// - Host driving line during device transmit is a collision.
// - On any error abort command, send four-character break, reset autobaud.
// - Host break keeps control register and debug mode.
// - Debugger held in reset while break lasts, released when line high.
// - Shared pin without unlock during reset stays general-purpose only.
// - Breakpoint opcode enters debug mode if enabled, else no-operation.
// - 16-bit run counter counts from debug exit, stops on entry or FFFFh.
// - Outside debug mode only a subset of commands; read protect limits more.
// - Open-drain half-duplex line; never transmit and receive together.
// - Control bit 7 is the debug mode flag; clearing it leaves debug mode (under read protect a control write keeps bit 7 set).
`timescale 1ns/10ps
`include "sdp_defs.vh"

module sdp_debug_port #(
    parameter CW = 13,
    parameter SHARED_PIN = 1'b0
) (
    input wire mclk,
    input wire resetn,
    input wire debug_line_i,
    output wire debug_line_o,
    output wire debug_line_oe,
    input wire shared_reset_pin,
    input wire read_protect_option,
    input wire cpu_opcode_valid,
    input wire [7:0] cpu_opcode,
    input wire [7:0] tx_data,
    input wire tx_valid,
    output wire tx_ready,
    output reg [7:0] rx_data_r,
    output reg rx_valid_r,
    output reg cmd_allowed_r,
    output reg cmd_abort_r,
    output reg [7:0] debugger_control_reg_r,
    output wire debug_mode_flag,
    output wire cpu_idle,
    output wire brk_as_nop,
    output reg [15:0] run_cnt_r,
    output reg framing_err_r,
    output reg collision_r,
    output reg break_seen_r,
    output reg pin_unlocked_r
);

localparam BW = CW - 3;
localparam S_IDLE = 3'd0;
localparam S_RX = 3'd1;
localparam S_TX = 3'd2;
localparam S_BRKOUT = 3'd3;
localparam S_HOLD = 3'd4;

reg line_m_r;
reg line_s_r;
reg rst_m_r;
reg rst_s_r;
reg [2:0] st_r;
reg [BW-1:0] bcnt_r;
reg [3:0] bits_r;
reg [3:0] low_bits_r;
reg [5:0] brk_bits_r;
reg [9:0] sh_r;
reg drive_low_r;
reg ab_clear_r;
reg cmd_first_r;
reg [2:0] key_cnt_r;
reg unl_ok_r;
reg rst_prev_r;
reg dbg_prev_r;
wire cal_done;
wire [BW-1:0] bit_cyc;
wire dbg_ok = SHARED_PIN ? pin_unlocked_r : 1'b1;
// Receiver also listens while the reset pin is low, to catch the key
wire dbg_listen = dbg_ok | !rst_s_r;
wire line = dbg_listen ? line_s_r : 1'b1;
wire bit_end = (bcnt_r == bit_cyc - {{(BW-1){1'b0}}, 1'b1});
wire mid_bit = (bcnt_r == {1'b0, bit_cyc[BW-1:1]});
// Reset pin release forces a fresh calibration
wire rst_release = rst_s_r & !rst_prev_r;
wire ab_clear = ab_clear_r | rst_release;
wire [31:0] key_word = `SDP_UNLOCK_KEY >> {key_cnt_r, 3'b000};
wire [31:0] rp_mask = `SDP_CMD_RP_MASK;
wire rp_blocked = read_protect_option & rp_mask[rx_data_r[4:0]];

// Open-drain: only ever pulls low
assign debug_line_o = 1'b0;
assign debug_line_oe = drive_low_r & dbg_ok;
assign debug_mode_flag = debugger_control_reg_r[`SDP_CTL_DEBUG_MODE_FLAG_BIT];
assign cpu_idle = debug_mode_flag;
assign brk_as_nop = cpu_opcode_valid && cpu_opcode == `SDP_BRK_OPCODE
    && !debugger_control_reg_r[`SDP_CTL_BRKEN_BIT];
assign tx_ready = (st_r == S_IDLE) && cal_done && line;

sdp_baud_meas #(.CW(CW)) u_meas (
    .mclk(mclk),
    .resetn(resetn),
    .clear(ab_clear),
    .line_s(line),
    .cal_done_r(cal_done),
    .bit_cyc_r(bit_cyc)
);

always @(posedge mclk) begin
    line_m_r <= debug_line_i;
    line_s_r <= line_m_r;
    rst_m_r <= shared_reset_pin;
    rst_s_r <= rst_m_r;
end

// Unlock key caught while the reset pin is low
always @(posedge mclk) begin
    if (!resetn) begin
        key_cnt_r <= 3'd0;
        unl_ok_r <= 1'b0;
        pin_unlocked_r <= 1'b0;
        rst_prev_r <= 1'b1;
    end else begin
        rst_prev_r <= rst_s_r;
        if (!rst_s_r) begin
            if (rx_valid_r && !unl_ok_r) begin
                if (rx_data_r == key_word[7:0]) begin
                    key_cnt_r <= key_cnt_r + 3'd1;
                    if (key_cnt_r == `SDP_UNLOCK_BYTES - 1)
                        unl_ok_r <= 1'b1;
                end else begin
                    key_cnt_r <= 3'd0;
                end
            end
        end else if (!rst_prev_r) begin
            pin_unlocked_r <= pin_unlocked_r | unl_ok_r;
            key_cnt_r <= 3'd0;
            unl_ok_r <= 1'b0;
        end
    end
end

// Serial engine
always @(posedge mclk) begin
    if (!resetn) begin
        st_r <= S_IDLE;
        bcnt_r <= {BW{1'b0}};
        bits_r <= 4'd0;
        low_bits_r <= 4'd0;
        brk_bits_r <= 6'd0;
        sh_r <= 10'h3ff;
        drive_low_r <= 1'b0;
        ab_clear_r <= 1'b0;
        rx_data_r <= 8'h00;
        rx_valid_r <= 1'b0;
        framing_err_r <= 1'b0;
        collision_r <= 1'b0;
        break_seen_r <= 1'b0;
        cmd_abort_r <= 1'b0;
    end else begin
        rx_valid_r <= 1'b0;
        ab_clear_r <= 1'b0;
        framing_err_r <= 1'b0;
        collision_r <= 1'b0;
        break_seen_r <= 1'b0;
        cmd_abort_r <= 1'b0;
        bcnt_r <= bit_end ? {BW{1'b0}} : bcnt_r + {{(BW-1){1'b0}}, 1'b1};
        case (st_r)
            S_IDLE: begin
                bcnt_r <= {BW{1'b0}};
                low_bits_r <= 4'd0;
                if (cal_done && !line) begin
                    st_r <= S_RX;
                    bits_r <= 4'd0;
                end else if (tx_valid && tx_ready) begin
                    sh_r <= {1'b1, tx_data, 1'b0};
                    bits_r <= 4'd0;
                    drive_low_r <= 1'b1;
                    st_r <= S_TX;
                end
            end
            S_RX: begin
                if (mid_bit) begin
                    sh_r <= {line, sh_r[9:1]};
                    bits_r <= bits_r + 4'd1;
                    low_bits_r <= line ? 4'd0 : low_bits_r + 4'd1;
                    // Nine full low bit times: sample after the ninth still low
                    if (!line && low_bits_r == `SDP_BREAK_BITS) begin
                        break_seen_r <= 1'b1;
                        cmd_abort_r <= 1'b1;
                        ab_clear_r <= 1'b1;
                        st_r <= S_HOLD;
                    end else if (bits_r == `SDP_CHAR_BITS - 1) begin
                        if (!line) begin
                            // Hold the count: the next cycle aborts and sends the break
                            framing_err_r <= 1'b1;
                            bits_r <= bits_r;
                        end else begin
                            rx_data_r <= sh_r[9:2];
                            rx_valid_r <= 1'b1;
                            st_r <= S_IDLE;
                        end
                    end
                end
                if (framing_err_r) begin
                    cmd_abort_r <= 1'b1;
                    bcnt_r <= {BW{1'b0}};
                    drive_low_r <= 1'b1;
                    brk_bits_r <= 6'd0;
                    st_r <= S_BRKOUT;
                end
            end
            S_TX: begin
                if (mid_bit && sh_r[0] && !line) begin
                    collision_r <= 1'b1;
                    bcnt_r <= {BW{1'b0}};
                    cmd_abort_r <= 1'b1;
                    brk_bits_r <= 6'd0;
                    drive_low_r <= 1'b1;
                    st_r <= S_BRKOUT;
                end else if (bit_end) begin
                    sh_r <= {1'b1, sh_r[9:1]};
                    drive_low_r <= !sh_r[1];
                    bits_r <= bits_r + 4'd1;
                    if (bits_r == `SDP_CHAR_BITS - 1) begin
                        drive_low_r <= 1'b0;
                        st_r <= S_IDLE;
                    end
                end
            end
            S_BRKOUT: begin
                drive_low_r <= 1'b1;
                if (bit_end) begin
                    brk_bits_r <= brk_bits_r + 6'd1;
                    if (brk_bits_r == `SDP_TX_BREAK_CHARS * `SDP_CHAR_BITS - 1) begin
                        drive_low_r <= 1'b0;
                        ab_clear_r <= 1'b1;
                        st_r <= S_HOLD;
                    end
                end
            end
            S_HOLD: begin
                // Held until line returns high
                drive_low_r <= 1'b0;
                ab_clear_r <= 1'b1;
                if (line)
                    st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
        endcase
    end
end

// Control register, command gating, breakpoints, run counter
always @(posedge mclk) begin
    if (!resetn) begin
        debugger_control_reg_r <= `SDP_CTL_RESET;
        cmd_first_r <= 1'b1;
        cmd_allowed_r <= 1'b0;
        run_cnt_r <= 16'h0000;
        dbg_prev_r <= 1'b0;
    end else begin
        dbg_prev_r <= debug_mode_flag;
        if (cmd_abort_r || st_r == S_HOLD) begin
            cmd_first_r <= 1'b1;
            cmd_allowed_r <= 1'b0;
        end else if (rx_valid_r && rst_s_r) begin
            if (cmd_first_r) begin
                cmd_allowed_r <= debug_mode_flag ? (rx_data_r <= `SDP_CMD_LAST && !rp_blocked)
                    : (rx_data_r == `SDP_CMD_REV || rx_data_r == `SDP_CMD_STAT
                    || rx_data_r == `SDP_CMD_WCTL || rx_data_r == `SDP_CMD_RCTL);
                cmd_first_r <= (rx_data_r != `SDP_CMD_WCTL);
            end else begin
                if (read_protect_option)
                    debugger_control_reg_r <= rx_data_r | (debugger_control_reg_r
                        & (8'h01 << `SDP_CTL_DEBUG_MODE_FLAG_BIT));
                else
                    debugger_control_reg_r <= rx_data_r;
                cmd_first_r <= 1'b1;
            end
        end
        if (cpu_opcode_valid && cpu_opcode == `SDP_BRK_OPCODE
            && debugger_control_reg_r[`SDP_CTL_BRKEN_BIT])
            debugger_control_reg_r[`SDP_CTL_DEBUG_MODE_FLAG_BIT] <= 1'b1;
        if (debug_mode_flag)
            run_cnt_r <= run_cnt_r;
        else if (dbg_prev_r)
            run_cnt_r <= 16'h0000;
        else if (run_cnt_r != `SDP_RUNCNT_MAX)
            run_cnt_r <= run_cnt_r + 16'h0001;
    end
end

endmodule // sdp_debug_port

// ===== src/sdp_defs.vh
`ifndef SDP_DEFS_VH
`define SDP_DEFS_VH

// Autobaud measurement limits, in system clock cycles per bit
`define SDP_BIT_MAX_CYC 512
`define SDP_BIT_MIN_CYC 4
`define SDP_CAL_BITS 8
`define SDP_BREAK_BITS 9
`define SDP_TX_BREAK_CHARS 4
`define SDP_CHAR_BITS 10
`define SDP_CAL_CHAR 8'h80
`define SDP_UNLOCK_KEY 32'hcd705aeb
`define SDP_UNLOCK_BYTES 4
`define SDP_BRK_OPCODE 8'h00
`define SDP_CTL_RESET 8'h00
`define SDP_CTL_DEBUG_MODE_FLAG_BIT 7
`define SDP_CTL_BRKEN_BIT 6
`define SDP_RUNCNT_MAX 16'hffff
// Command bytes the gating logic classifies
`define SDP_CMD_REV 8'h00
`define SDP_CMD_STAT 8'h02
`define SDP_CMD_RUNCNT 8'h03
`define SDP_CMD_WCTL 8'h04
`define SDP_CMD_RCTL 8'h05
`define SDP_CMD_LAST 8'h12
// Commands refused under read protect, one bit per command code
`define SDP_CMD_RP_MASK 32'h00070ec0

`endif

// ===== src/sdp_baud_meas.v
`timescale 1ns/10ps
`include "sdp_defs.vh"

// Measures the eight-bit low run of the calibration character
module sdp_baud_meas #(
    parameter CW = 13
) (
    input wire mclk,
    input wire resetn,
    input wire clear,
    input wire line_s,
    output reg cal_done_r,
    output reg [CW-4:0] bit_cyc_r
);

reg [CW-1:0] cnt_r;
reg meas_r;
reg prev_r;

always @(posedge mclk) begin
    if (!resetn || clear) begin
        cal_done_r <= 1'b0;
        bit_cyc_r <= {(CW-3){1'b0}};
        cnt_r <= {CW{1'b0}};
        meas_r <= 1'b0;
        prev_r <= 1'b1;
    end else begin
        prev_r <= line_s;
        if (!cal_done_r) begin
            if (prev_r && !line_s) begin
                meas_r <= 1'b1;
                cnt_r <= {{(CW-1){1'b0}}, 1'b1};
            end else if (meas_r && !line_s) begin
                if (cnt_r != {CW{1'b1}})
                    cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
            end else if (meas_r && line_s) begin
                meas_r <= 1'b0;
                // Eight low bits: divide by eight for one bit period
                if (cnt_r[CW-1:3] >= `SDP_BIT_MIN_CYC && cnt_r[CW-1:3] <= `SDP_BIT_MAX_CYC) begin
                    bit_cyc_r <= cnt_r[CW-1:3];
                    cal_done_r <= 1'b1;
                end
            end
        end
    end
end

endmodule // sdp_baud_meas

// ===== dv/sdp_debug_port_properties.sv
`timescale 1ns/10ps
module sdp_chk (
    input logic mclk, input logic resetn, input logic debug_line_o, input logic debug_line_oe,
    input logic cpu_opcode_valid, input logic [7:0] cpu_opcode, input logic rx_valid_r, input logic cmd_abort_r,
    input logic [7:0] debugger_control_reg_r, input logic debug_mode_flag, input logic brk_as_nop,
    input logic [15:0] run_cnt_r, input logic framing_err_r, input logic collision_r, input logic break_seen_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_idle;
        !$past(resetn) |-> (!debug_line_oe) [*8];
    endproperty
    a_idle: assert property (p_idle) else $error("line driven after reset");
    property p_open;
        debug_line_o == 1'b0;
    endproperty
    a_open: assert property (p_open) else $error("line driven high");
    property p_duplex;
        rx_valid_r |-> !debug_line_oe;
    endproperty
    a_duplex: assert property (p_duplex) else $error("receive while sending");
    property p_abort;
        (framing_err_r || break_seen_r || collision_r) |-> ##[0:2] cmd_abort_r;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort on error");
    property p_err_break;
        (framing_err_r || collision_r) |-> ##[0:16] debug_line_oe;
    endproperty
    a_err_break: assert property (p_err_break) else $error("no break after error");
    property p_ctl_kept;
        break_seen_r |-> ##1 $stable(debugger_control_reg_r) [*8];
    endproperty
    a_ctl_kept: assert property (p_ctl_kept) else $error("control changed by break");
    property p_mode;
        debug_mode_flag == debugger_control_reg_r[7];
    endproperty
    a_mode: assert property (p_mode) else $error("mode flag mismatch");
    property p_nop;
        cpu_opcode_valid && cpu_opcode == 8'h00 && !debugger_control_reg_r[6] |-> brk_as_nop;
    endproperty
    a_nop: assert property (p_nop) else $error("break opcode not ignored");
    property p_enter;
        cpu_opcode_valid && cpu_opcode == 8'h00 && debugger_control_reg_r[6] |-> ##[1:3] debug_mode_flag;
    endproperty
    a_enter: assert property (p_enter) else $error("break opcode ignored");
    property p_run_hold;
        debug_mode_flag && $past(debug_mode_flag) |-> $stable(run_cnt_r);
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("counter runs in debug");
endmodule // sdp_chk
bind sdp_debug_port sdp_chk i_chk (
    .mclk(mclk), .resetn(resetn), .debug_line_o(debug_line_o), .debug_line_oe(debug_line_oe),
    .cpu_opcode_valid(cpu_opcode_valid), .cpu_opcode(cpu_opcode), .rx_valid_r(rx_valid_r),
    .cmd_abort_r(cmd_abort_r), .debugger_control_reg_r(debugger_control_reg_r),
    .debug_mode_flag(debug_mode_flag), .brk_as_nop(brk_as_nop), .run_cnt_r(run_cnt_r),
    .framing_err_r(framing_err_r), .collision_r(collision_r), .break_seen_r(break_seen_r)
);

// ===== dv/sdp_host_model.sv
`timescale 1ns/10ps
module sdp_host_model #(
    parameter int BIT = 16
) (
    input wire mclk,
    input wire line,
    output logic host_low
);
    initial host_low = 1'b0;
    task automatic drive(input logic v, input int n);
        @(posedge mclk);
        #1 host_low = v;
        repeat (n - 1) @(posedge mclk);
    endtask
    // Start low, data LSB first, stop released if stop_ok else held low, never driven high
    task automatic send_byte(input logic [7:0] b, input logic stop_ok);
        logic [9:0] f;
        f = {~stop_ok, ~b, 1'b1};
        for (int i = 0; i < 10; i++) drive(f[i], BIT);
        drive(1'b0, 1);
    endtask
    task automatic hold_low(input int nbits);
        drive(1'b1, nbits * BIT);
        drive(1'b0, 1);
    endtask
    task automatic get_byte(output logic [7:0] b);
        int i;
        for (i = 0; i < 4000 && line !== 1'b0; i++) @(posedge mclk);
        repeat (BIT / 2) @(posedge mclk);
        for (i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge mclk);
            b[i] = line;
        end
        // Return only once the stop bit has ended
        repeat (BIT + BIT / 2) @(posedge mclk);
    endtask
endmodule // sdp_host_model

// ===== dv/sdp_debug_port_tb_top.sv
`timescale 1ns/10ps
module sdp_debug_port_tb_top;
    localparam int BIT = 16;
    logic mclk, resetn, rd_prot, op_valid, tx_valid, host_low;
    logic [7:0] op, tx_data;
    logic [3:0] seen;
    logic pin_rst_n, host2_low;
    wire oe, tx_ready, rx_valid, allowed, flag, nop, fe, col, breakpoint_opcode;
    wire [7:0] rx_data, ctl;
    wire [15:0] run_cnt;
    wire oe2, unl;
    wire [7:0] ctl2;
    wire line2 = ~(oe2 | host2_low);
    wire line = ~(oe | host_low);
    int n_errors, checked;
    sdp_debug_port i_dut (.mclk(mclk), .resetn(resetn), .debug_line_i(line), .debug_line_o(), .debug_line_oe(oe),
        .shared_reset_pin(1'b1), .read_protect_option(rd_prot), .cpu_opcode_valid(op_valid), .cpu_opcode(op),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data_r(rx_data), .rx_valid_r(rx_valid),
        .cmd_allowed_r(allowed), .cmd_abort_r(), .debugger_control_reg_r(ctl), .debug_mode_flag(flag),
        .cpu_idle(), .brk_as_nop(nop), .run_cnt_r(run_cnt), .framing_err_r(fe), .collision_r(col),
        .break_seen_r(breakpoint_opcode), .pin_unlocked_r());
    sdp_host_model #(.BIT(BIT)) i_host (.mclk(mclk), .line(line), .host_low(host_low));
    // Shared-pin variant, reached only through the unlock key
    sdp_debug_port #(.SHARED_PIN(1'b1)) i_dut_pin (.mclk(mclk), .resetn(resetn), .debug_line_i(line2),
        .debug_line_o(), .debug_line_oe(oe2), .shared_reset_pin(pin_rst_n), .read_protect_option(1'b0),
        .cpu_opcode_valid(1'b0), .cpu_opcode(8'h00), .tx_data(8'h00), .tx_valid(1'b0), .tx_ready(),
        .rx_data_r(), .rx_valid_r(), .cmd_allowed_r(), .cmd_abort_r(), .debugger_control_reg_r(ctl2),
        .debug_mode_flag(), .cpu_idle(), .brk_as_nop(), .run_cnt_r(), .framing_err_r(), .collision_r(),
        .break_seen_r(), .pin_unlocked_r(unl));
    sdp_host_model #(.BIT(BIT)) i_host2 (.mclk(mclk), .line(line2), .host_low(host2_low));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) seen <= seen | {breakpoint_opcode, col, fe, rx_valid};
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("n_errors=%0d checked=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Index 4 waits for a released, high line
    task automatic wait_for(input int k);
        int i;
        for (i = 0; i < 3000 && (k < 4 ? seen[k] : line & ~oe) !== 1'b1; i++) @(posedge mclk);
        if (i == 3000) begin
            n_errors++;
            print_verdict();
        end
    endtask
    task automatic settle();
        wait_for(4);
        repeat (50 * BIT) @(posedge mclk);
        wait_for(4);
    endtask
    task automatic host_byte(input logic [7:0] b);
        seen = 4'h0;
        i_host.send_byte(b, 1'b1);
        wait_for(0);
        repeat (2) @(posedge mclk);
        chk(16'(rx_data), 16'(b));
    endtask
    // Ready is looked at settled, then the next edge takes the byte
    task automatic tx_send(input logic [7:0] d);
        int i;
        @(posedge mclk);
        #1 tx_data = d;
        tx_valid = 1'b1;
        for (i = 0; i < 3000 && tx_ready !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        if (i == 3000) begin
            n_errors++;
            print_verdict();
        end
        @(posedge mclk);
        #1 tx_valid = 1'b0;
    endtask
    task automatic pulse_op();
        @(posedge mclk);
        #1 op_valid = 1'b1;
        #1 chk(16'(nop), {15'h0000, ~ctl[6]});
        @(posedge mclk);
        #1 op_valid = 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic t_main();
        logic [7:0] got;
        logic [15:0] cnt;
        int n;
        repeat (200) @(posedge mclk);
        chk(16'(oe), 16'h0000);
        chk(16'(ctl), 16'h0000);
        i_host.send_byte(8'h80, 1'b1);
        host_byte(8'h03);
        chk(16'(allowed), 16'h0000);
        host_byte(8'h04);
        host_byte(8'hc0);
        chk(16'(ctl), 16'h00c0);
        host_byte(8'h03);
        chk(16'(allowed), 16'h0001);
        fork
            i_host.get_byte(got);
            tx_send(8'ha5);
        join
        chk(16'(got), 16'h00a5);
        host_byte(8'h04);
        host_byte(8'h00);
        chk(16'(flag), 16'h0000);
        pulse_op();
        chk(16'(flag), 16'h0000);
        host_byte(8'h04);
        host_byte(8'h40);
        chk(16'(run_cnt > 16'h0100), 16'h0001);
        pulse_op();
        chk(16'(flag), 16'h0001);
        cnt = run_cnt;
        repeat (50) @(posedge mclk);
        chk(run_cnt, cnt);
        #1 rd_prot = 1'b1;
        host_byte(8'h04);
        host_byte(8'h40);
        chk(16'(flag), 16'h0001);
        host_byte(8'h07);
        chk(16'(allowed), 16'h0000);
        #1 rd_prot = 1'b0;
        seen = 4'h0;
        i_host.hold_low(12);
        chk(16'(seen[3]), 16'h0001);
        settle();
        chk(16'(ctl), 16'h00c0);
        i_host.send_byte(8'h80, 1'b1);
        host_byte(8'h05);
        seen = 4'h0;
        i_host.send_byte(8'h55, 1'b0);
        chk(16'(seen[1]), 16'h0001);
        for (n = 0; n < 2000 && oe === 1'b1; n++) @(posedge mclk);
        chk(16'(n > 560 && n < 660), 16'h0001);
        settle();
        i_host.send_byte(8'h80, 1'b1);
        seen = 4'h0;
        fork
            tx_send(8'hff);
            begin
                repeat (3 * BIT) @(posedge mclk);
                i_host.hold_low(1);
            end
        join
        wait_for(2);
        settle();
    endtask
    task automatic t_unlock();
        logic [39:0] key;
        logic [23:0] wr;
        key = 40'hcd705aeb80;
        wr = 24'h800480;
        for (int i = 0; i < 3; i++) i_host2.send_byte(wr[8 * i +: 8], 1'b1);
        repeat (4) @(posedge mclk);
        chk(16'(ctl2), 16'h0000);
        #1 pin_rst_n = 1'b0;
        repeat (100) @(posedge mclk);
        for (int i = 0; i < 5; i++) i_host2.send_byte(key[8 * i +: 8], 1'b1);
        chk(16'(unl), 16'h0000);
        @(posedge mclk);
        #1 pin_rst_n = 1'b1;
        repeat (6) @(posedge mclk);
        chk(16'(unl), 16'h0001);
        for (int i = 0; i < 3; i++) i_host2.send_byte(wr[8 * i +: 8], 1'b1);
        repeat (4) @(posedge mclk);
        chk(16'(ctl2), 16'h0080);
    endtask
    initial begin
        resetn = 1'b0;
        rd_prot = 1'b0;
        op_valid = 1'b0;
        op = 8'h00;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        seen = 4'h0;
        pin_rst_n = 1'b1;
        n_errors = 0;
        checked = 0;
        repeat (12) @(posedge mclk);
        #1 resetn = 1'b1;
        t_main();
        t_unlock();
        print_verdict();
    end
endmodule // sdp_debug_port_tb_top
